// ===== verilog/pmg_pkg.sv
// constants, codes and carriers for the microphone input and multi-function pin block
// assumes a single 25 MHz system clock and an 8-bit register port
package pmg_pkg;

  localparam logic [7:0] PMG_CLK_DIV_ADDR = 8'h1f;
  localparam logic [7:0] PMG_EDGE_ADDR = 8'h20;
  localparam logic [7:0] PMG_PIN_ADDR = 8'h21;

  localparam logic [7:0] PMG_CLK_DIV_RESET = 8'h40;
  localparam logic [7:0] PMG_EDGE_RESET = 8'h00;
  localparam logic [7:0] PMG_PIN_RESET = 8'h22;

  localparam int PMG_DIV_LSB = 0;
  localparam int PMG_EDGE_LSB = 4;
  localparam int PMG_FUNC_LSB = 4;
  localparam int PMG_DRV_LSB = 0;
  localparam int PMG_PIN_RSVD_BIT = 3;

  localparam int PMG_CHANNEL_PAIRS = 4;
  localparam int PMG_WORD_W = 8;
  localparam int PMG_FIFO_DEPTH = 16;

  localparam longint PMG_CLK_HZ = 64'd25_000_000;
  localparam longint PMG_MIC_TOP_48K_HZ = 64'd6_144_000;
  localparam longint PMG_MIC_TOP_44K_HZ = 64'd5_644_800;
  localparam int PMG_NCO_W = 24;

  typedef enum logic [3:0] {
    PMG_FN_OFF = 4'h0,
    PMG_FN_GEN_OUT = 4'h1,
    PMG_FN_IRQ = 4'h2,
    PMG_FN_SEC_OUT = 4'h3,
    PMG_FN_MIC_CLK = 4'h4,
    PMG_FN_RSVD5 = 4'h5,
    PMG_FN_RSVD6 = 4'h6,
    PMG_FN_RSVD7 = 4'h7,
    PMG_FN_BIAS_IN = 4'h8,
    PMG_FN_GEN_IN = 4'h9,
    PMG_FN_MASTER_CLK = 4'ha,
    PMG_FN_CHAIN_IN = 4'hb,
    PMG_FN_MIC_ONE = 4'hc,
    PMG_FN_MIC_TWO = 4'hd,
    PMG_FN_MIC_THREE = 4'he,
    PMG_FN_MIC_FOUR = 4'hf
  } pmg_func_type;

  typedef enum logic [2:0] {
    PMG_DRV_HIZ = 3'h0,
    PMG_DRV_PUSH_PULL = 3'h1,
    PMG_DRV_LOW_WEAK_HIGH = 3'h2,
    PMG_DRV_LOW_ONLY = 3'h3,
    PMG_DRV_WEAK_LOW_HIGH = 3'h4,
    PMG_DRV_HIGH_ONLY = 3'h5,
    PMG_DRV_RSVD6 = 3'h6,
    PMG_DRV_RSVD7 = 3'h7
  } pmg_drive_type;

  typedef struct packed {
    logic drive_en;
    logic level;
    logic pull_up;
    logic pull_dn;
  } pmg_pin_type;

  // accumulator step giving two toggles per mic clock period
  function automatic logic [PMG_NCO_W-1:0] pmg_nco_step(input logic [1:0] div,
                                                        input logic fam48);
    longint f;
    f = fam48 ? PMG_MIC_TOP_48K_HZ : PMG_MIC_TOP_44K_HZ;
    case (div)
      2'h0: f = f / 2;
      2'h1: f = f / 4;
      2'h2: f = f / 8;
      default: f = f;
    endcase
    return PMG_NCO_W'(((64'd2 * f) << PMG_NCO_W) / PMG_CLK_HZ);
  endfunction

endpackage

// ===== verilog/pmg_fifo.sv
// synchronous FIFO with valid/ready on both sides
// assumes one clock; output data is read straight from the storage array
`timescale 1ns/1ps
module pmg_fifo import pmg_pkg::*; #(
  parameter int WIDTH = PMG_WORD_W,
  parameter int DEPTH = PMG_FIFO_DEPTH
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic push;
  logic pop;
  logic full;
  logic empty;
  logic [AW:0] next_wr_ptr;
  logic [AW:0] next_rd_ptr;

  assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty = (wr_ptr == rd_ptr);
  assign in_ready_o = !full;
  assign next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
  assign next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
  assign out_data_o = mem[rd_ptr[AW-1:0]];
  assign push = in_valid_i && !full;
  assign pop = out_ready_i && !empty;

  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ptr <= '0;
    end else if (push) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_ptr <= '0;
    end else if (pop) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end

  // not-empty held in a flop so the valid output leaves a register
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      out_valid_o <= 1'b0;
    end else begin
      out_valid_o <= next_wr_ptr != next_rd_ptr;
    end
  end

  fifo_fill_c: cover property (@(posedge mclk_i) disable iff (!nrst_i) full);
endmodule

// ===== verilog/pmg_capture.sv
// latches the two channels of each microphone data input on the chosen clock edges
// assumes one-cycle rise/fall pulses that coincide with the mic clock changing
`timescale 1ns/1ps
module pmg_capture import pmg_pkg::*; #(
  parameter int PAIRS = PMG_CHANNEL_PAIRS
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic rise_i,
  input wire logic fall_i,
  input wire logic [PAIRS-1:0] data_i,
  input wire logic [PAIRS-1:0] edge_sel_i,
  output logic [2*PAIRS-1:0] chan_o,
  output logic push_o,
  output logic [2*PAIRS-1:0] word_o
);
  logic [2*PAIRS-1:0] next_chan;

  // odd channel in bit 2n, even channel in bit 2n+1
  for (genvar n = 0; n < PAIRS; n++) begin : g_pair
    logic odd_take;
    logic even_take;
    assign odd_take = edge_sel_i[n] ? rise_i : fall_i;
    assign even_take = edge_sel_i[n] ? fall_i : rise_i;
    assign next_chan[2*n] = odd_take ? data_i[n] : chan_o[2*n];
    assign next_chan[2*n+1] = even_take ? data_i[n] : chan_o[2*n+1];
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      chan_o <= '0;
    end else begin
      chan_o <= next_chan;
    end
  end

  // a whole frame is ready once the rising edge has been taken
  assign push_o = rise_i;
  assign word_o = next_chan;

  one_fall_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    fall_i && !edge_sel_i[0] |=> chan_o[0] == $past(data_i[0]))
    else $error("channel 1 not taken on falling edge");
  one_rise_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    rise_i && edge_sel_i[0] |=> chan_o[0] == $past(data_i[0]) && $stable(chan_o[1]))
    else $error("channel 1 not taken on rising edge when swapped");
  pair_edge_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    fall_i && !edge_sel_i[3] |=> chan_o[6] == $past(data_i[3]) && $stable(chan_o[7]))
    else $error("channel 7 not taken on falling edge");
endmodule

// ===== verilog/pmg_pin_config.sv
// microphone clock generation, microphone capture and multi-function pin routing
// assumes synchronous pin inputs, 25 MHz mclk_i and a byte-wide register port
// Overview of operation
// - divider 0: 2.8224 or 3.072 MHz mic clock
// - divider 1 and 2: half and quarter
// - divider 3: 5.6448 or 6.144 MHz
// - divider in bits 1-0, upper bits read-write
// - edge 0: channel 1 falling, channel 2 rising
// - edge 1: capture edges swapped
// - bits 6-4 do the same for pairs
// - function 0 disables pin, 1 general output
// - function 2, the reset value, drives interrupt
// - function 3 secondary output, 4 mic clock
// - function 8 pin switches microphone bias supply
// - function 9 general input, 10 master clock
// - function 11 chain serial input
// - functions 12-15 pin replaces mic data input
// - drive 0 high impedance, 1 push-pull
// - drive 2, reset value, low active weak high
// - drives 3, 4, 5 partial or weak drive
// - drive field ignored for secondary output
// - clock divider register resets to 40h
`timescale 1ns/1ps
module pmg_pin_config import pmg_pkg::*; #(
  parameter int FIFO_DEPTH = PMG_FIFO_DEPTH
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  output logic [7:0] reg_rdata_o,
  input wire logic rate_family_48k_i,
  input wire logic irq_i,
  input wire logic general_output_i,
  input wire logic secondary_serial_output_i,
  input wire logic [PMG_CHANNEL_PAIRS-1:0] mic_data_input_i,
  input wire logic multi_function_pin_i,
  output logic multi_function_pin_o,
  output logic multi_function_pin_oe_o,
  output logic multi_function_pin_pull_up_o,
  output logic multi_function_pin_pull_dn_o,
  output logic mic_clock_o,
  output logic bias_enable_input_o,
  output logic general_input_o,
  output logic master_clock_o,
  output logic chain_serial_input_o,
  output logic [PMG_WORD_W-1:0] mic_word_o,
  output logic mic_word_valid_o,
  input wire logic mic_word_ready_i,
  output logic mic_overrun_o
);
  logic [7:0] mic_clock_divider_config;
  logic [3:0] mic_data_edge_select;
  logic [3:0] multi_pin_function;
  logic [2:0] multi_pin_drive;
  logic [PMG_CHANNEL_PAIRS-1:0] edge_sel;
  logic [1:0] mic_clock_divider;
  logic [PMG_NCO_W:0] nco_sum;
  logic [PMG_NCO_W-1:0] nco_acc;
  logic mic_rise;
  logic mic_fall;
  logic [PMG_CHANNEL_PAIRS-1:0] mic_data_sel;
  logic [2:0] rate_prev;
  logic [4:0] rate_age;
  logic cap_push;
  logic [PMG_WORD_W-1:0] cap_word;
  logic fifo_in_ready;
  logic want_drive;
  logic force_push_pull;
  logic want_level;
  pmg_pin_type next_pin;

  assign mic_clock_divider = mic_clock_divider_config[PMG_DIV_LSB +: 2];

  // register writes
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mic_clock_divider_config <= PMG_CLK_DIV_RESET;
    end else if (reg_wr_i && reg_addr_i == PMG_CLK_DIV_ADDR) begin
      mic_clock_divider_config <= reg_wdata_i;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mic_data_edge_select <= PMG_EDGE_RESET[PMG_EDGE_LSB +: 4];
    end else if (reg_wr_i && reg_addr_i == PMG_EDGE_ADDR) begin
      mic_data_edge_select <= reg_wdata_i[PMG_EDGE_LSB +: 4];
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      multi_pin_function <= PMG_PIN_RESET[PMG_FUNC_LSB +: 4];
      multi_pin_drive <= PMG_PIN_RESET[PMG_DRV_LSB +: 3];
    end else if (reg_wr_i && reg_addr_i == PMG_PIN_ADDR) begin
      multi_pin_function <= reg_wdata_i[PMG_FUNC_LSB +: 4];
      multi_pin_drive <= reg_wdata_i[PMG_DRV_LSB +: 3];
    end
  end

  // registered read-back, one cycle after the address
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      case (reg_addr_i)
        PMG_CLK_DIV_ADDR: reg_rdata_o <= mic_clock_divider_config;
        PMG_EDGE_ADDR: reg_rdata_o <= {mic_data_edge_select, 4'h0};
        PMG_PIN_ADDR: reg_rdata_o <= {multi_pin_function, 1'b0, multi_pin_drive};
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // mic clock: phase accumulator, two carries per output period
  assign nco_sum = {1'b0, nco_acc} + {1'b0, pmg_nco_step(mic_clock_divider,
                                                         rate_family_48k_i)};

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      nco_acc <= '0;
      mic_clock_o <= 1'b0;
      mic_rise <= 1'b0;
      mic_fall <= 1'b0;
    end else begin
      nco_acc <= nco_sum[PMG_NCO_W-1:0];
      mic_clock_o <= mic_clock_o ^ nco_sum[PMG_NCO_W];
      mic_rise <= nco_sum[PMG_NCO_W] && !mic_clock_o;
      mic_fall <= nco_sum[PMG_NCO_W] && mic_clock_o;
    end
  end

  // edge bit 7 belongs to input one, bit 4 to input four
  for (genvar n = 0; n < PMG_CHANNEL_PAIRS; n++) begin : g_in
    assign edge_sel[n] = mic_data_edge_select[PMG_CHANNEL_PAIRS-1-n];
    assign mic_data_sel[n] = (multi_pin_function == 4'(PMG_FN_MIC_ONE) + 4'(n)) ?
                             multi_function_pin_i : mic_data_input_i[n];
  end

  pmg_capture #(
    .PAIRS(PMG_CHANNEL_PAIRS)
  ) u_capture (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .rise_i(mic_rise),
    .fall_i(mic_fall),
    .data_i(mic_data_sel),
    .edge_sel_i(edge_sel),
    .chan_o(),
    .push_o(cap_push),
    .word_o(cap_word)
  );

  pmg_fifo #(
    .WIDTH(PMG_WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .in_data_i(cap_word),
    .in_valid_i(cap_push),
    .in_ready_o(fifo_in_ready),
    .out_data_o(mic_word_o),
    .out_valid_o(mic_word_valid_o),
    .out_ready_i(mic_word_ready_i)
  );

  // a frame that finds the FIFO full is dropped and flagged for one cycle
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mic_overrun_o <= 1'b0;
    end else begin
      mic_overrun_o <= cap_push && !fifo_in_ready;
    end
  end

  // output functions of the pin
  always_comb begin
    want_drive = 1'b0;
    force_push_pull = 1'b0;
    want_level = 1'b0;
    case (pmg_func_type'(multi_pin_function))
      PMG_FN_GEN_OUT: begin
        want_drive = 1'b1;
        want_level = general_output_i;
      end
      PMG_FN_IRQ: begin
        want_drive = 1'b1;
        want_level = irq_i;
      end
      PMG_FN_SEC_OUT: begin
        force_push_pull = 1'b1;
        want_level = secondary_serial_output_i;
      end
      PMG_FN_MIC_CLK: begin
        want_drive = 1'b1;
        want_level = mic_clock_o;
      end
      default: want_drive = 1'b0;
    endcase
  end

  // drive style for the wanted level
  always_comb begin
    next_pin = '0;
    next_pin.level = want_level;
    if (force_push_pull) begin
      next_pin.drive_en = 1'b1;
    end else if (want_drive) begin
      case (pmg_drive_type'(multi_pin_drive))
        PMG_DRV_PUSH_PULL: next_pin.drive_en = 1'b1;
        PMG_DRV_LOW_WEAK_HIGH: begin
          next_pin.drive_en = !want_level;
          next_pin.pull_up = want_level;
        end
        PMG_DRV_LOW_ONLY: next_pin.drive_en = !want_level;
        PMG_DRV_WEAK_LOW_HIGH: begin
          next_pin.drive_en = want_level;
          next_pin.pull_dn = !want_level;
        end
        PMG_DRV_HIGH_ONLY: next_pin.drive_en = want_level;
        default: next_pin.drive_en = 1'b0;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      multi_function_pin_o <= 1'b0;
      multi_function_pin_oe_o <= 1'b0;
      multi_function_pin_pull_up_o <= 1'b0;
      multi_function_pin_pull_dn_o <= 1'b0;
    end else begin
      multi_function_pin_o <= next_pin.level;
      multi_function_pin_oe_o <= next_pin.drive_en;
      multi_function_pin_pull_up_o <= next_pin.pull_up;
      multi_function_pin_pull_dn_o <= next_pin.pull_dn;
    end
  end

  // input functions of the pin
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bias_enable_input_o <= 1'b0;
      general_input_o <= 1'b0;
      master_clock_o <= 1'b0;
      chain_serial_input_o <= 1'b0;
    end else begin
      bias_enable_input_o <= (multi_pin_function == PMG_FN_BIAS_IN) &&
                             multi_function_pin_i;
      general_input_o <= (multi_pin_function == PMG_FN_GEN_IN) &&
                         multi_function_pin_i;
      master_clock_o <= (multi_pin_function == PMG_FN_MASTER_CLK) &&
                        multi_function_pin_i;
      chain_serial_input_o <= (multi_pin_function == PMG_FN_CHAIN_IN) &&
                              multi_function_pin_i;
    end
  end

  // cycles since divider or rate family last changed, so a period that
  // straddles a rate change is not judged
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rate_prev <= 3'h0;
      rate_age <= 5'h00;
    end else begin
      rate_prev <= {rate_family_48k_i, mic_clock_divider};
      if ({rate_family_48k_i, mic_clock_divider} != rate_prev) begin
        rate_age <= 5'h00;
      end else if (rate_age != 5'h1f) begin
        rate_age <= rate_age + 5'h01;
      end
    end
  end

  div_zero_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    $fell(mic_clock_o) && mic_clock_divider == 2'h0 && rate_age > 5'h18
    |-> $past(mic_clock_o, 4) && !$past(mic_clock_o, 6))
    else $error("mic clock half period wrong for divider 0");
  div_slow_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    $fell(mic_clock_o) && mic_clock_divider == 2'h2 && rate_age > 5'h18
    |-> $past(mic_clock_o, 16) && !$past(mic_clock_o, 19))
    else $error("mic clock half period wrong for divider 2");
  div_fast_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    $fell(mic_clock_o) && mic_clock_divider == 2'h3 && rate_age > 5'h18
    |-> $past(mic_clock_o, 2) && !$past(mic_clock_o, 4))
    else $error("mic clock half period wrong for divider 3");
  edge_rsvd_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    reg_addr_i == PMG_EDGE_ADDR |=> reg_rdata_o[3:0] == 4'h0)
    else $error("edge register low bits not zero");
  irq_route_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    multi_pin_function == PMG_FN_IRQ && multi_pin_drive == PMG_DRV_PUSH_PULL
    |=> multi_function_pin_oe_o && multi_function_pin_o == $past(irq_i))
    else $error("interrupt not on pin");
  sec_out_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    multi_pin_function == PMG_FN_SEC_OUT
    |=> multi_function_pin_oe_o && multi_function_pin_o == $past(secondary_serial_output_i))
    else $error("secondary output not driven");
  pin_off_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    multi_pin_function == PMG_FN_OFF || multi_pin_function inside {[4'h5:4'h7]}
    || multi_pin_drive == PMG_DRV_HIZ && multi_pin_function != PMG_FN_SEC_OUT
    |=> !multi_function_pin_oe_o && !multi_function_pin_pull_up_o)
    else $error("pin driven while off");
  weak_high_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    multi_pin_function == PMG_FN_GEN_OUT && multi_pin_drive == PMG_DRV_LOW_WEAK_HIGH
    && general_output_i |=> multi_function_pin_pull_up_o && !multi_function_pin_oe_o)
    else $error("weak high not applied");
  gen_in_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    multi_pin_function == PMG_FN_GEN_IN |=> general_input_o == $past(multi_function_pin_i))
    else $error("general input not followed");

  mic_pin_c: cover property (@(posedge mclk_i) disable iff (!nrst_i)
    multi_pin_function == PMG_FN_MIC_ONE && cap_push);
  overrun_c: cover property (@(posedge mclk_i) disable iff (!nrst_i) mic_overrun_o);
  bias_c: cover property (@(posedge mclk_i) disable iff (!nrst_i) $rose(bias_enable_input_o));
endmodule

// ===== verification/pmg_far_side.sv
// far-side model: two microphones on each data line and a host on the pin
// assumes mic_clock_i is registered in the mclk_i domain
`timescale 1ns/1ps
module pmg_far_side (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic mic_clock_i,
  input wire logic host_drive_i,
  input wire logic pin_level_i,
  input wire logic pin_oe_i,
  input wire logic pull_up_i,
  input wire logic pull_dn_i,
  output logic [3:0] mic_data_o,
  output logic pin_o
);
  int seed = 32'h8b0c3501;
  logic clk_seen = 1'b0;
  logic host_val = 1'b0;
  logic last = 1'b0;
  initial mic_data_o = 4'h0;
  // each mic drives after its own edge, the other one takes over next
  always @(posedge mclk_i) begin
    last <= pin_o;
    clk_seen <= nrst_i ? mic_clock_i : 1'b0;
    if (nrst_i && mic_clock_i != clk_seen) begin
      mic_data_o <= 4'($random(seed));
      host_val <= 1'($random(seed));
    end
  end
  // undriven and unpulled wire drifts every cycle
  assign pin_o = pin_oe_i ? pin_level_i : host_drive_i ? host_val :
    pull_up_i ? 1'b1 : pull_dn_i ? 1'b0 : ~last;
endmodule

// ===== verification/test_pdm_input_and_multi_function_pin_config.sv
// self-checking bench for the mic capture and multi-function pin block
// assumes the far-side model in pmg_far_side.sv
`timescale 1ns/1ps
module test_pdm_input_and_multi_function_pin_config import pmg_pkg::*; ;
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, word;
  logic wr = 1'b0, fam = 1'b0, irq = 1'b0, general_output = 1'b0, sdo = 1'b0, wready = 1'b0;
  logic stall = 1'b0, pin_in, pin_o, oe, pu, pd, mclk_o, wvalid, ovr;
  logic bias, general_input, mck, chain;
  logic drain = 1'b0;
  logic [3:0] mic;
  int seed = 32'h8b0c3501;
  int mismatches = 0;
  int num_checks = 0;
  int cyc = 0, drops = 0, ovr_seen = 0, qlen = 0;
  longint rises = 0;
  logic [7:0] r_div = 8'h40, r_edge = 8'h00, r_pin = 8'h22, cprev = 8'h22, frame = 8'h00;
  logic [7:0] q[$];
  logic [4:0] epin = 5'h0;
  logic [3:0] ein = 4'h0;
  logic ev = 1'b0, prev_clk = 1'b0;
  logic [7:0] ra[4] = '{8'h1f, 8'h20, 8'h21, 8'h55};
  longint ftab[8] = '{2822400, 1411200, 705600, 5644800, 3072000, 1536000, 768000, 6144000};

  always #20 mclk_i = ~mclk_i;

  pmg_pin_config #(.FIFO_DEPTH(16)) i_pmg_pin_config (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rdata_o(rdata), .rate_family_48k_i(fam), .irq_i(irq),
    .general_output_i(general_output), .secondary_serial_output_i(sdo), .mic_data_input_i(mic),
    .multi_function_pin_i(pin_in), .multi_function_pin_o(pin_o),
    .multi_function_pin_oe_o(oe), .multi_function_pin_pull_up_o(pu),
    .multi_function_pin_pull_dn_o(pd), .mic_clock_o(mclk_o), .bias_enable_input_o(bias),
    .general_input_o(general_input), .master_clock_o(mck), .chain_serial_input_o(chain),
    .mic_word_o(word), .mic_word_valid_o(wvalid), .mic_word_ready_i(wready),
    .mic_overrun_o(ovr));

  pmg_far_side i_pmg_far_side (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .mic_clock_i(mclk_o), .host_drive_i(r_pin[7]),
    .pin_level_i(pin_o), .pin_oe_i(oe), .pull_up_i(pu), .pull_dn_i(pd),
    .mic_data_o(mic), .pin_o(pin_in));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  function automatic logic [7:0] rd(input logic [7:0] a);
    case (a)
      8'h1f: return r_div;
      8'h20: return r_edge;
      8'h21: return r_pin;
      default: return 8'h00;
    endcase
  endfunction

  // {oe, level, pull_up, pull_dn, level_matters}
  function automatic logic [4:0] pin_exp(input logic [7:0] c, input logic v, input logic s);
    if (c[7:4] == 4'h3) return {1'b1, s, 3'b001};
    if (c[7:4] != 4'h1 && c[7:4] != 4'h2 && c[7:4] != 4'h4) return 5'h0;
    case (c[2:0])
      3'h1: return {1'b1, v, 3'b001};
      3'h2: return v ? 5'b00100 : 5'b10001;
      3'h3: return v ? 5'b00000 : 5'b10001;
      3'h4: return v ? 5'b11001 : 5'b00010;
      3'h5: return v ? 5'b11001 : 5'b00000;
      default: return 5'h0;
    endcase
  endfunction

  function automatic logic mt(input logic [3:0] g, input logic [4:0] e);
    return g[3] === e[4] && g[1:0] === e[2:1] && (!e[0] || g[2] === e[3]);
  endfunction

  always @(posedge mclk_i) begin
    irq <= 1'($random(seed));
    general_output <= 1'($random(seed));
    sdo <= 1'($random(seed));
    wready <= stall ? 1'b0 : drain ? 1'b1 : 1'($random(seed));
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      results();
    end else if (nrst_i) begin
      if (ev) begin
        check(32'(mt({oe, pin_o, pu, pd}, epin) || (cprev[7:4] == 4'h4 &&
          mt({oe, pin_o, pu, pd}, pin_exp(cprev, mclk_o, 1'b0)))), 32'h1,
          "pin drive");
        check({bias, general_input, mck, chain}, ein, "pin input");
      end
      ev = 1'b1;
      cprev = r_pin;
      epin = pin_exp(r_pin, r_pin[7:4] == 4'h1 ? general_output : r_pin[7:4] == 4'h2 ? irq : mclk_o, sdo);
      ein = {4{pin_in}} & {r_pin[7:4] == 4'h8, r_pin[7:4] == 4'h9, r_pin[7:4] == 4'ha,
        r_pin[7:4] == 4'hb};
      if (ovr === 1'b1) ovr_seen++;
      // occupancy before this edge's pop decides a drop, as in the buffer
      qlen = q.size();
      if (wvalid === 1'b1 && wready) begin
        if (q.size() == 0) check(32'h1, 32'h0, "word with empty model");
        else check(word, q.pop_front(), "mic word");
      end
      if (mclk_o != prev_clk) begin
        for (int p = 0; p < 4; p++) begin
          frame[2*p + int'(mclk_o ^ r_edge[7-p])] = r_pin[7:4] == 4'(12 + p) ? pin_in : mic[p];
        end
        if (mclk_o && qlen < 16) q.push_back(frame);
        else if (mclk_o) drops++;
        if (mclk_o) rises++;
      end
      prev_clk = mclk_o;
      if (wr) begin
        case (addr)
          8'h1f: r_div <= wdata;
          8'h20: r_edge <= {wdata[7:4], 4'h0};
          8'h21: r_pin <= {wdata[7:4], 1'b0, wdata[2:0]};
          default: ;
        endcase
      end
    end
  end

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk_i);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [7:0] a);
    @(posedge mclk_i);
    addr <= a;
    repeat (2) @(posedge mclk_i);
    check(rdata, rd(a), "register read");
  endtask

  initial begin
    repeat (5) @(posedge mclk_i);
    nrst_i <= 1'b1;
    foreach (ra[i]) rreg(ra[i]);
    wreg(8'h1f, 8'hff);
    wreg(8'h20, 8'hff);
    wreg(8'h21, 8'h3d);
    wreg(8'h55, 8'hff);
    foreach (ra[i]) rreg(ra[i]);
    $display("register test done");
    for (int d = 0; d < 8; d++) begin
      fam <= d[2];
      wreg(8'h1f, {6'h10, 2'(d)});
      repeat (200) @(posedge mclk_i);
      rises = 0;
      repeat (2500) @(posedge mclk_i);
      check(32'(rises * 10000 + 20000 >= ftab[d] && rises * 10000 <= ftab[d] + 20000),
        32'h1, "mic clock rate");
    end
    $display("mic clock test done");
    for (int f = 0; f < 16; f++) begin
      for (int d = 0; d < 6; d++) begin
        // reserved codes never written
        if (f < 5 || f > 7) begin
          wreg(8'h21, {4'(f), 1'b0, 3'(d)});
          repeat (12) @(posedge mclk_i);
        end
      end
    end
    $display("pin function test done");
    for (int p = 0; p < 4; p++) begin
      wreg(8'h20, 8'($random(seed)));
      wreg(8'h21, {4'(12 + p), 4'h1});
      repeat (800) @(posedge mclk_i);
    end
    stall <= 1'b1;
    repeat (300) @(posedge mclk_i);
    @(negedge mclk_o);
    @(posedge mclk_i);
    stall <= 1'b0;
    drain <= 1'b1;
    repeat (300) @(posedge mclk_i);
    @(negedge mclk_i);
    check(32'(drops > 0), 32'h1, "buffer filled");
    check(32'(ovr_seen), 32'(drops), "overrun count");
    check(32'(q.size()), 32'(wvalid), "buffer drained");
    $display("mic stream test done");
    results();
  end
endmodule
